// *** swdr_consts.svh ***
// Timing constants for the supervisor watchdog reset block
`ifndef SWDR_CONSTS_SVH
`define SWDR_CONSTS_SVH
`define SWDR_CLK_PERIOD_NS     10
`define SWDR_RST_TIMEOUT_MS    10
`define SWDR_WDG_TIMEOUT_MS    3300
// Cycle counts at the 10 ns clock, written out so no 32-bit product overflows
`define SWDR_RST_TIMEOUT_CYC   32'h000F4240
`define SWDR_WDG_TIMEOUT_CYC   32'h13AB6680
`define SWDR_CNT_W             32
`endif

// *** swdr_cpu.sv ***
// Processor model that kicks the watchdog
`timescale 1ns/1ps
module swdr_cpu (
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_hang,
    output logic      o_kick);
    int n = 0;
    initial o_kick = 1'b0;
    always @(posedge i_clk) begin
        n <= (n == 15 || !i_rst_n) ? 0 : n + 1;
        if (n == 15 && i_rst_n && !i_hang) o_kick <= #1 ~o_kick;
    end
endmodule

// *** swdr_pkg.sv ***
// Types for the supervisor watchdog reset block
package swdr_pkg;
    typedef enum logic [1:0] {
        SWDR_ST_HOLD,
        SWDR_ST_TIMEOUT,
        SWDR_ST_RUN
    } swdr_state_t;

    typedef struct packed {
        logic [1:0]  rst_sync;
        logic [1:0]  kick_sync;
        logic [1:0]  mr_sync;
        logic        kick_prev;
        swdr_state_t state;
        logic [31:0] rst_cnt;
        logic [31:0] wdg_cnt;
        logic        reset_n_out;
        logic        reset_out;
        logic        expired;
    } swdr_regs_t;
endpackage

// *** swdr_top.sv ***
// Supervisor reset generator with watchdog timer
// Functional notes
// - Active-low reset low on supply low, manual reset low, or watchdog expiry.
// - Active-high reset output mirrors the same causes and hold, inverted.
// - After supply recovers, reset stays asserted one full reset timeout.
// - Manual reset low from outside starts a reset.
// - Reset held while manual reset low, then one timeout after release.
// - Watchdog input must toggle within watchdog timeout, else reset triggers.
// - Watchdog count clears on reset, manual reset, and any kick edge.
// - After expiry, reset held exactly one reset timeout, then released.
// - Manual reset synchroniser resets high, so manual reset reads deasserted.
// - Watchdog stops during reset and restarts from zero after release.
// - Kick pulses of 150 ns or more are seen as toggles.
`timescale 1ns/1ps
`include "swdr_consts.svh"

module swdr_top #(
    parameter logic [31:0] RST_TIMEOUT_CYC = `SWDR_RST_TIMEOUT_CYC,
    parameter logic [31:0] WDG_TIMEOUT_CYC = `SWDR_WDG_TIMEOUT_CYC
) (
    input  wire logic i_clk,
    input  wire logic i_arst_n,
    input  wire logic i_supply_low,
    input  wire logic i_manual_reset_n,
    input  wire logic i_watchdog_kick_in,
    output logic      o_reset_n,
    output logic      o_reset,
    output logic      o_wdg_expired
);

    ////////////////////////////////////////////////////////////////////////////////
    // Reset release

    logic [1:0] arst_sync_r;
    logic       rst_n;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            arst_sync_r <= 2'h0;
        end else begin
            arst_sync_r <= {arst_sync_r[0], 1'b1};
        end
    end

    assign rst_n = arst_sync_r[1];

    ////////////////////////////////////////////////////////////////////////////////
    // State

    swdr_pkg::swdr_regs_t q_r;
    swdr_pkg::swdr_regs_t q_nxt;
    logic                 mr_low;
    logic                 kick_edge;
    logic                 cause;

    always_comb begin
        q_nxt = q_r;
        // Kick and manual reset inputs taken into two-stage synchronisers; supply low used directly
        q_nxt.kick_sync = {q_r.kick_sync[0], i_watchdog_kick_in};
        q_nxt.mr_sync   = {q_r.mr_sync[0], i_manual_reset_n};
        q_nxt.kick_prev = q_r.kick_sync[1];
        mr_low    = !q_r.mr_sync[1];
        // 150 ns pulse spans many clock periods, so always caught
        kick_edge = q_r.kick_sync[1] ^ q_r.kick_prev;
        cause     = i_supply_low || mr_low;
        q_nxt.expired = 1'b0;
        case (q_r.state)
            swdr_pkg::SWDR_ST_HOLD: begin
                q_nxt.rst_cnt = 32'h0;
                q_nxt.wdg_cnt = 32'h0;
                if (!cause) begin
                    q_nxt.state = swdr_pkg::SWDR_ST_TIMEOUT;
                end
            end
            swdr_pkg::SWDR_ST_TIMEOUT: begin
                q_nxt.wdg_cnt = 32'h0;
                if (cause) begin
                    q_nxt.state = swdr_pkg::SWDR_ST_HOLD;
                end else if (q_r.rst_cnt >= RST_TIMEOUT_CYC - 32'h1) begin
                    q_nxt.state = swdr_pkg::SWDR_ST_RUN;
                    q_nxt.rst_cnt = 32'h0;
                end else begin
                    q_nxt.rst_cnt = q_r.rst_cnt + 32'h1;
                end
            end
            swdr_pkg::SWDR_ST_RUN: begin
                if (cause) begin
                    q_nxt.state = swdr_pkg::SWDR_ST_HOLD;
                    q_nxt.wdg_cnt = 32'h0;
                end else if (kick_edge) begin
                    q_nxt.wdg_cnt = 32'h0;
                end else if (q_r.wdg_cnt >= WDG_TIMEOUT_CYC - 32'h1) begin
                    q_nxt.state = swdr_pkg::SWDR_ST_TIMEOUT;
                    q_nxt.wdg_cnt = 32'h0;
                    q_nxt.rst_cnt = 32'h0;
                    q_nxt.expired = 1'b1;
                end else begin
                    q_nxt.wdg_cnt = q_r.wdg_cnt + 32'h1;
                end
            end
            default: begin
                q_nxt.state = swdr_pkg::SWDR_ST_HOLD;
            end
        endcase
        q_nxt.reset_n_out = (q_nxt.state == swdr_pkg::SWDR_ST_RUN);
        q_nxt.reset_out   = (q_nxt.state != swdr_pkg::SWDR_ST_RUN);
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            q_r.rst_sync    <= 2'h0;
            q_r.kick_sync   <= 2'h0;
            q_r.mr_sync     <= 2'h3;
            q_r.kick_prev   <= 1'b0;
            q_r.state       <= swdr_pkg::SWDR_ST_HOLD;
            q_r.rst_cnt     <= 32'h0;
            q_r.wdg_cnt     <= 32'h0;
            q_r.reset_n_out <= 1'b0;
            q_r.reset_out   <= 1'b1;
            q_r.expired     <= 1'b0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign o_reset_n     = q_r.reset_n_out;
    assign o_reset       = q_r.reset_out;
    assign o_wdg_expired = q_r.expired;

endmodule

// *** swdr_top_asserts.sv ***
// Checker for the supervisor watchdog reset block
`timescale 1ns/1ps
module swdr_chk #(parameter logic [31:0] RST_TIMEOUT_CYC = 32'h14,
    parameter logic [31:0] WDG_TIMEOUT_CYC = 32'h32) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_supply_low,
    input wire logic i_manual_reset_n,
    input wire logic i_watchdog_kick_in,
    input wire logic o_reset_n,
    input wire logic o_reset,
    input wire logic o_wdg_expired);
    localparam int RA = RST_TIMEOUT_CYC - 1, RB = RST_TIMEOUT_CYC + 4;
    logic [31:0] run_r;
    always_ff @(posedge i_clk or negedge i_arst_n)
        if (!i_arst_n) run_r <= 32'h0;
        else run_r <= (!o_reset_n || $changed(i_watchdog_kick_in)) ? 32'h0 : run_r + 32'h1;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    sequence s_mr_low; !i_manual_reset_n [*6]; endsequence
    a_pol_mirror: assert property (o_reset == !o_reset_n) else $error("pol");
    a_supply_rst: assert property (i_supply_low |=> !o_reset_n) else $error("sup");
    a_mr_start: assert property ($fell(i_manual_reset_n) |-> ##[1:5] !o_reset_n) else $error("m");
    a_mr_hold: assert property (s_mr_low |-> !o_reset_n) else $error("mh");
    a_hold_len: assert property ($rose(o_reset_n) |-> $past(!o_reset_n, RA)) else $error("h");
    a_exp_rel: assert property (o_wdg_expired |-> ##[RA:RB] o_reset_n) else $error("rl");
    a_exp_rst: assert property (o_wdg_expired |-> !o_reset_n ##1 !o_wdg_expired) else $error("x");
    a_wdg_run: assert property (o_reset_n |-> run_r <= WDG_TIMEOUT_CYC + 32'h6)
        else $error("w");
endmodule
bind swdr_top swdr_chk #(.RST_TIMEOUT_CYC(RST_TIMEOUT_CYC), .WDG_TIMEOUT_CYC(WDG_TIMEOUT_CYC))
    u_c (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_supply_low(i_supply_low),
    .i_manual_reset_n(i_manual_reset_n), .i_watchdog_kick_in(i_watchdog_kick_in),
    .o_reset_n(o_reset_n), .o_reset(o_reset), .o_wdg_expired(o_wdg_expired));

// *** tb.sv ***
// Testbench for the supervisor watchdog reset block
`timescale 1ns/1ps
module tb;
    localparam int RT = 20, WT = 50;
    logic c = 0, ar_n = 0, sup = 0, mr_n = 1, hang = 0, kick, rst_n, rst, exp;
    int mismatches = 0, checks_done = 0, n;
    swdr_top #(.RST_TIMEOUT_CYC(RT), .WDG_TIMEOUT_CYC(WT)) u_dut (.i_clk(c), .i_arst_n(ar_n),
        .i_supply_low(sup), .i_manual_reset_n(mr_n), .i_watchdog_kick_in(kick),
        .o_reset_n(rst_n), .o_reset(rst), .o_wdg_expired(exp));
    swdr_cpu u_cpu (.i_clk(c), .i_rst_n(rst_n), .i_hang(hang), .o_kick(kick));
    initial forever #5 c = ~c;
    task close_out();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task chk(input logic seen, input logic want);
        checks_done++;
        if (seen !== want) begin
            mismatches++;
            $display("[FAIL] %0t mismatch", $time);
        end
    endtask
    task cyc(input int k);
        repeat (k) @(posedge c);
        #1;
    endtask
    task wait_for(input bit on_exp);
        n = 0;
        while ((on_exp ? exp : rst_n) !== 1'b1) begin
            cyc(1);
            n++;
            if (n > 300) begin
                chk(1'b0, 1'b1);
                close_out();
            end
        end
    endtask
    task t_sup();
        sup = 1;
        cyc(3);
        chk(rst_n, 1'b0);
        chk(rst, 1'b1);
        sup = 0;
        wait_for(0);
        chk(n >= RT - 1 && n <= RT + 4, 1'b1);
        $display("supply test end");
    endtask
    task t_mr();
        mr_n = 0;
        cyc(30);
        chk(rst_n, 1'b0);
        mr_n = 1;
        wait_for(0);
        chk(n >= RT - 1 && n <= RT + 6, 1'b1);
        $display("manual test end");
    endtask
    task t_wdg();
        repeat (2 * WT) begin
            cyc(1);
            chk(exp, 1'b0);
        end
        hang = 1;
        wait_for(1);
        chk(n + 17 >= WT && n <= WT + 4, 1'b1);
        chk(rst_n, 1'b0);
        hang = 0;
        wait_for(0);
        chk(n >= RT - 1 && n <= RT + 4, 1'b1);
        $display("watchdog test end");
    endtask
    initial begin
        cyc(6);
        ar_n = 1;
        wait_for(0);
        t_sup();
        t_mr();
        t_wdg();
        close_out();
    end
endmodule
